// [inc/pfss_pkg.sv]
// package of constants and types for the paper feed stepper sequencer
// How it works
// - drive each winding bipolar, polarity reversing
// - half-step: alternate one and two windings
// - one dot line equals four steps
// - stop on one winding, start on two
// - ramp step rate up after start
// - keep stepping until the job ends
// - optional reduced holding current while waiting
// - long idle switches all excitation off
// - fixed-current drive at normal reference level
// - abnormal condition stops motor at once
// - refuse to start without paper
`default_nettype none
package pfss_pkg;
	// timing at 25 MHz
	localparam int unsigned CLK_HZ          = 25_000_000;
	localparam int unsigned CRUISE_US       = 1250;   // step period at full speed
	localparam int unsigned START_US        = 5000;   // first step period of a ramp
	localparam int unsigned RAMP_DEC_US     = 250;    // period shrink per step
	localparam int unsigned IDLE_MS         = 1000;   // hold time before excitation off
	localparam int unsigned CRUISE_CYC      = CRUISE_US * (CLK_HZ / 1_000_000);
	localparam int unsigned START_CYC       = START_US * (CLK_HZ / 1_000_000);
	localparam int unsigned RAMP_DEC_CYC    = RAMP_DEC_US * (CLK_HZ / 1_000_000);
	localparam int unsigned IDLE_CYC        = IDLE_MS * (CLK_HZ / 1_000);
	localparam int unsigned STEPS_PER_LINE  = 4;
	localparam logic [2:0]  PHASE_RST       = 3'h0;   // single winding A
	// current reference selection
	localparam logic [1:0]  IREF_OFF        = 2'h0;
	localparam logic [1:0]  IREF_HOLD       = 2'h1;   // reduced holding level
	localparam logic [1:0]  IREF_RUN        = 2'h2;   // normal stepping level

	// winding drive: enable and polarity per winding
	typedef struct packed {
		logic a_en;
		logic a_pos;
		logic b_en;
		logic b_pos;
	} pfss_drive_s;

	typedef enum logic [2:0] {
		PFSS_IDLE  = 3'b000,
		PFSS_START = 3'b001,
		PFSS_RUN   = 3'b011,
		PFSS_SETTL = 3'b010,
		PFSS_HOLD  = 3'b110,
		PFSS_FAULT = 3'b111
	} pfss_state_e;
endpackage
`default_nettype wire

// [logic/pfss_phase_map.sv]
// decoder from half-step phase index to winding drive
`default_nettype none
module pfss_phase_map
	import pfss_pkg::*;
(
	// phase and excitation request
	input  wire logic [2:0]  phase_i,
	input  wire logic        energise_i,
	// winding drive
	output pfss_drive_s      drive_o
);
	// eight-state order A, AB, B, B-A, -A, -A-B, -B, -BA
	// polarity bit reverses the current in a whole winding
	always_comb begin
		drive_o = '0;
		if (energise_i) begin
			unique case (phase_i)
				3'h0: drive_o = '{1'b1, 1'b1, 1'b0, 1'b0};
				3'h1: drive_o = '{1'b1, 1'b1, 1'b1, 1'b1};
				3'h2: drive_o = '{1'b0, 1'b0, 1'b1, 1'b1};
				3'h3: drive_o = '{1'b1, 1'b0, 1'b1, 1'b1};
				3'h4: drive_o = '{1'b1, 1'b0, 1'b0, 1'b0};
				3'h5: drive_o = '{1'b1, 1'b0, 1'b1, 1'b0};
				3'h6: drive_o = '{1'b0, 1'b0, 1'b1, 1'b0};
				3'h7: drive_o = '{1'b1, 1'b1, 1'b1, 1'b0};
			endcase
		end
	end
endmodule
`default_nettype wire

// [logic/pfss_sequencer.sv]
// paper feed stepper sequencer: controller side of the feed motor
`default_nettype none
module pfss_sequencer
	import pfss_pkg::*;
#(
	parameter int unsigned START_CYC_P  = START_CYC,
	parameter int unsigned CRUISE_CYC_P = CRUISE_CYC,
	parameter int unsigned RAMP_DEC_P   = RAMP_DEC_CYC,
	parameter int unsigned IDLE_CYC_P   = IDLE_CYC,
	parameter bit          HOLD_EN_P    = 1'b1
)
(
	// clock and reset
	input  wire logic        mclk_i,
	input  wire logic        rst_n_i,
	// job request
	input  wire logic        start_i,
	input  wire logic [15:0] lines_i,
	input  wire logic        reverse_i,
	input  wire logic        abort_i,
	// sensor
	input  wire logic        paper_sense_i,
	// job status
	output logic             busy_o,
	output logic             done_o,
	output logic             refused_o,
	output logic             line_o,
	output logic             fault_o,
	// motor drive
	output pfss_drive_s      drive_o,
	output logic [1:0]       iref_o
);
	localparam logic [23:0] START_L  = 24'(START_CYC_P);
	localparam logic [23:0] CRUISE_L = 24'(CRUISE_CYC_P);
	localparam logic [23:0] DEC_L    = 24'(RAMP_DEC_P);
	localparam logic [31:0] IDLE_L   = 32'(IDLE_CYC_P);

	pfss_state_e  state_ff;
	logic [2:0]   phase_ff;
	logic [23:0]  period_ff;
	logic [23:0]  tick_ff;
	logic [1:0]   sub_ff;
	logic [15:0]  left_ff;
	logic [31:0]  idle_ff;
	logic         dir_ff;
	logic         energ_ff;
	logic         done_ff;
	logic         refused_ff;
	logic         line_ff;
	logic [1:0]   iref_ff;
	logic         paper_ok;
	logic         tick_end;
	logic         go;

	// low level means reflection, paper present
	assign paper_ok = ~paper_sense_i;
	// start only with paper and a nonzero job
	assign go       = start_i && paper_ok && (lines_i != 16'h0000);
	assign tick_end = (tick_ff == 24'h0000_01) || (tick_ff == 24'h0000_00);

	// main state machine
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			state_ff <= PFSS_IDLE;
		end else begin
			unique case (state_ff)
				PFSS_IDLE, PFSS_HOLD: begin
					if (abort_i)
						state_ff <= PFSS_FAULT;
					else if (go)
						state_ff <= PFSS_START;
					else if (state_ff == PFSS_HOLD && idle_ff == 32'h0000_0000)
						state_ff <= PFSS_IDLE;
				end
				PFSS_START: state_ff <= abort_i ? PFSS_FAULT : PFSS_RUN;
				PFSS_RUN: begin
					// any abnormal input ends the job at once
					if (abort_i)
						state_ff <= PFSS_FAULT;
					else if (tick_end && sub_ff == 2'h3 && left_ff == 16'h0001)
						state_ff <= PFSS_SETTL;
				end
				PFSS_SETTL: state_ff <= abort_i ? PFSS_FAULT : PFSS_HOLD;
				PFSS_FAULT: state_ff <= abort_i ? PFSS_FAULT : PFSS_IDLE;
				default:    state_ff <= PFSS_FAULT;
			endcase
		end
	end

	// step timing, ramp and line counting
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			tick_ff   <= 24'h0000_00;
			period_ff <= 24'h0000_00;
			sub_ff    <= 2'h0;
			left_ff   <= 16'h0000;
			dir_ff    <= 1'b0;
		end else if (state_ff == PFSS_START) begin
			// every job begins at the slow start period
			period_ff <= START_L;
			tick_ff   <= START_L;
			// the move made in START is the first step of the first line
			// so 4 steps per line still end on a one-winding state; after a
			// fault the phase may already be odd and no move is made, so that
			// first line is one step short but the stop still lands on one winding
			sub_ff    <= 2'h1;
		end else if ((state_ff == PFSS_IDLE || state_ff == PFSS_HOLD) && go) begin
			left_ff <= lines_i;
			dir_ff  <= reverse_i;
		end else if (state_ff == PFSS_RUN) begin
			// step issued when the period counter expires
			if (tick_end) begin
				// shorten period each step down to cruise
				if (period_ff > CRUISE_L + DEC_L)
					period_ff <= period_ff - DEC_L;
				else
					period_ff <= CRUISE_L;
				tick_ff <= period_ff;
				// four steps advance one dot line
				sub_ff  <= sub_ff + 2'h1;
				if (sub_ff == 2'h3)
					left_ff <= left_ff - 16'h0001;
			end else begin
				tick_ff <= tick_ff - 24'h0000_01;
			end
		end
	end

	// phase index: advances once per step
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			phase_ff <= PHASE_RST;
		end else if (state_ff == PFSS_START && !phase_ff[0]) begin
			// motion starts from a two-winding state
			phase_ff <= dir_ff ? phase_ff - 3'h1 : phase_ff + 3'h1;
		end else if (state_ff == PFSS_RUN && tick_end && !abort_i) begin
			phase_ff <= dir_ff ? phase_ff - 3'h1 : phase_ff + 3'h1;
		end
	end

	// excitation and current reference
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			energ_ff <= 1'b0;
			iref_ff  <= IREF_OFF;
			idle_ff  <= 32'h0000_0000;
		end else begin
			unique case (state_ff)
				PFSS_START, PFSS_RUN: begin
					// excitation stays on for the whole job
					// fixed-current drive at the normal reference
					energ_ff <= 1'b1;
					iref_ff  <= IREF_RUN;
					idle_ff  <= IDLE_L;
				end
				PFSS_SETTL: begin
					// waiting uses the reduced holding level
					energ_ff <= HOLD_EN_P;
					iref_ff  <= HOLD_EN_P ? IREF_HOLD : IREF_OFF;
				end
				PFSS_HOLD: begin
					if (idle_ff != 32'h0000_0000)
						idle_ff <= idle_ff - 32'h0000_0001;
					else begin
						energ_ff <= 1'b0;
						iref_ff  <= IREF_OFF;
					end
				end
				default: begin
					// fault and idle leave windings unpowered
					energ_ff <= 1'b0;
					iref_ff  <= IREF_OFF;
				end
			endcase
		end
	end

	// status pulses
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			done_ff    <= 1'b0;
			refused_ff <= 1'b0;
			line_ff    <= 1'b0;
		end else begin
			done_ff <= (state_ff == PFSS_SETTL);
			// refusal reported when paper is missing
			refused_ff <= start_i && !paper_ok &&
				(state_ff == PFSS_IDLE || state_ff == PFSS_HOLD);
			line_ff <= (state_ff == PFSS_RUN) && tick_end && (sub_ff == 2'h3);
		end
	end

	// decode phase into bipolar winding drive
	pfss_phase_map u_map (
		.phase_i    (phase_ff),
		.energise_i (energ_ff),
		.drive_o    (drive_o)
	);

	assign busy_o    = (state_ff == PFSS_START) || (state_ff == PFSS_RUN);
	assign done_o    = done_ff;
	assign refused_o = refused_ff;
	assign line_o    = line_ff;
	assign fault_o   = (state_ff == PFSS_FAULT);
	assign iref_o    = iref_ff;

	// assertions beside the logic
	a_stop_one_phase: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(state_ff == PFSS_SETTL) |-> !phase_ff[0])
		else $error("motor stopped in a two-winding state");
	a_start_two_phase: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(state_ff == PFSS_RUN && $past(state_ff) == PFSS_START) |-> phase_ff[0])
		else $error("motion did not start in two-winding state");
	a_no_paper_start: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(state_ff == PFSS_IDLE && start_i && paper_sense_i && !abort_i)
		|=> state_ff != PFSS_START)
		else $error("job started without paper");
	a_abort_stops: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(abort_i && busy_o) |=> ##1 (drive_o == '0 && iref_o == IREF_OFF))
		else $error("drive not removed after abort");
	a_run_excited: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(state_ff == PFSS_RUN && $past(state_ff) == PFSS_RUN) |-> iref_o == IREF_RUN)
		else $error("excitation dropped during job");
	a_ramp_no_faster: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(state_ff == PFSS_RUN) |-> (period_ff >= CRUISE_L && period_ff <= START_L))
		else $error("step period outside ramp bounds");
	a_line_four_steps: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		line_o |-> $past(sub_ff) == 2'h3)
		else $error("line pulse not after four steps");
	a_step_one_move: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(state_ff == PFSS_RUN && $changed(phase_ff)) |-> $changed(phase_ff[0]))
		else $error("step did not alternate winding count");
	a_sense_level: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(state_ff == PFSS_START) |-> $past(!paper_sense_i || abort_i))
		else $error("start taken with sensor high");
	a_idle_off: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(state_ff == PFSS_IDLE && $past(state_ff) == PFSS_IDLE) |-> drive_o == '0)
		else $error("windings energised while idle");

	c_job_done:  cover property (@(posedge mclk_i) disable iff (!rst_n_i) done_o);
	c_refused:   cover property (@(posedge mclk_i) disable iff (!rst_n_i) refused_o);
	c_fault:     cover property (@(posedge mclk_i) disable iff (!rst_n_i) fault_o);
	c_reverse:   cover property (@(posedge mclk_i) disable iff (!rst_n_i) busy_o && dir_ff);
endmodule
`default_nettype wire

// [bench/pfss_mech_model.sv]
// feed mechanism model: stepper position tracker and paper sensor
`default_nettype none
module pfss_mech_model
	import pfss_pkg::*;
(
	// clock and reset
	input  wire logic        mclk_i,
	input  wire logic        rst_n_i,
	// windings and paper
	input  wire pfss_drive_s drive_i,
	input  wire logic        paper_in_i,
	// sensor and observed motion
	output logic             sense_o,
	output var int           pos_o,
	output var int           bad_o,
	output var int           gap_first_o,
	output var int           gap_last_o
);
	timeunit 1ns;
	timeprecision 1ns;

	int last_idx;
	int nsteps;
	int cnt;
	int cur;

	function automatic int idx_of(input pfss_drive_s d);
		casez ({d.a_en, d.a_pos, d.b_en, d.b_pos})
			4'b110?: return 0;
			4'b1111: return 1;
			4'b0?11: return 2;
			4'b1011: return 3;
			4'b100?: return 4;
			4'b1010: return 5;
			4'b0?10: return 6;
			4'b1110: return 7;
			default: return 8;
		endcase
	endfunction

	assign sense_o = paper_in_i ? 1'b0 : 1'b1;

	// only a move of one half step counts, others are bad
	always @(posedge mclk_i) begin
		cur = idx_of(drive_i);
		cnt++;
		if (rst_n_i !== 1'b1) begin
			last_idx = PHASE_RST;
			pos_o = 0;
			bad_o = 0;
			nsteps = 0;
			cnt = 0;
		end else if (cur != 8 && cur != last_idx) begin
			if (cur == (last_idx + 1) % 8) pos_o++;
			else if (cur == (last_idx + 7) % 8) pos_o--;
			else bad_o++;
			nsteps++;
			if (nsteps == 2) gap_first_o = cnt;
			gap_last_o = cnt;
			cnt = 0;
			last_idx = cur;
		end
	end
endmodule
`default_nettype wire

// [bench/pfss_sequencer_tb_top.sv]
// self-checking testbench for the paper feed stepper sequencer
`default_nettype none
module pfss_sequencer_tb_top
	import pfss_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int IDLE_P = 50;
	logic        mclk, rst_n, start, reverse, abort, paper, sense;
	logic [15:0] lines;
	logic        busy, done, refused, line, fault;
	logic [1:0]  iref;
	pfss_drive_s drive;
	int          pos, bad, gap_f, gap_l;
	int          err_count = 0;
	int          total_checks = 0;

	// shortened counts keep the run brief
	pfss_sequencer #(.START_CYC_P(20), .CRUISE_CYC_P(5), .RAMP_DEC_P(5),
		.IDLE_CYC_P(IDLE_P), .HOLD_EN_P(1'b1)) uut (.mclk_i(mclk), .rst_n_i(rst_n),
		.start_i(start), .lines_i(lines), .reverse_i(reverse), .abort_i(abort),
		.paper_sense_i(sense), .busy_o(busy), .done_o(done), .refused_o(refused),
		.line_o(line), .fault_o(fault), .drive_o(drive), .iref_o(iref));

	pfss_mech_model u_mech (.mclk_i(mclk), .rst_n_i(rst_n), .drive_i(drive),
		.paper_in_i(paper), .sense_o(sense), .pos_o(pos), .bad_o(bad),
		.gap_first_o(gap_f), .gap_last_o(gap_l));

	// clock at 25 MHz
	initial mclk = 1'b0;
	always #20 mclk = ~mclk;

	task automatic stop_test();
		if (err_count == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input logic ok, input string msg);
		total_checks++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask

	// every scenario starts from a fresh reset held two cycles
	task automatic do_reset();
		@(negedge mclk);
		rst_n = 1'b0;
		start = 1'b0;
		abort = 1'b0;
		repeat (2) @(negedge mclk);
		rst_n = 1'b1;
	endtask

	// start is held for exactly one sampling edge
	task automatic launch(input logic [15:0] n, input logic rev);
		lines = n;
		reverse = rev;
		start = 1'b1;
		@(negedge mclk);
		start = 1'b0;
	endtask

	task automatic wait_done(output int nl);
		nl = 0;
		for (int i = 0; i < 3000; i++) begin
			@(negedge mclk);
			if (line === 1'b1) nl++;
			if (done === 1'b1) break;
		end
	endtask

	// two lines forward, then idle until excitation drops
	task automatic t_feed();
		int nl;
		int w;
		do_reset();
		chk(busy === 1'b0 && drive === '0 && iref === IREF_OFF, "not quiet after reset");
		launch(16'h0002, 1'b0);
		// windings are powered one edge after the start is taken
		chk(busy === 1'b1 && drive === '0, "start not taken");
		@(negedge mclk);
		chk(drive.a_en === 1'b1 && drive.b_en === 1'b1, "bad start");
		chk(iref === IREF_RUN, "run current missing");
		wait_done(nl);
		chk(done === 1'b1 && nl == 2 && pos == 8 && bad == 0, "wrong step count");
		chk((drive.a_en ^ drive.b_en) === 1'b1, "stopped on two windings");
		chk(iref === IREF_HOLD, "no holding current");
		chk(gap_f > gap_l, "no speed ramp");
		for (w = 0; w < 2 * IDLE_P && iref !== IREF_OFF; w++) @(negedge mclk);
		chk(iref === IREF_OFF && drive === '0 && w >= IDLE_P - 2, "idle off wrong");
	endtask

	// reverse line; a second start while busy is ignored
	task automatic t_reverse();
		int nl;
		do_reset();
		launch(16'h0001, 1'b1);
		// second start lands on the START edge and must be ignored
		launch(16'h0005, 1'b0);
		chk({drive.a_en, drive.a_pos, drive.b_en, drive.b_pos} === 4'b1110, "bad dir");
		wait_done(nl);
		chk(done === 1'b1 && nl == 1 && pos == -4 && bad == 0, "reverse wrong");
		chk(gap_f > gap_l, "no ramp after off");
		// restart straight from the holding state, forward again
		launch(16'h0001, 1'b0);
		wait_done(nl);
		chk(done === 1'b1 && nl == 1 && pos == 0 && bad == 0, "restart from hold wrong");
	endtask

	// start without paper is refused by a single pulse
	task automatic t_no_paper();
		do_reset();
		paper = 1'b0;
		launch(16'h0001, 1'b0);
		chk(refused === 1'b1 && busy === 1'b0, "no refusal");
		@(negedge mclk);
		chk(refused === 1'b0 && drive === '0 && pos == 0, "refusal not one pulse");
		paper = 1'b1;
	endtask

	// abnormal condition in mid-job drops all drive
	task automatic t_abort();
		do_reset();
		launch(16'h0003, 1'b0);
		repeat (30) @(negedge mclk);
		abort = 1'b1;
		repeat (2) @(negedge mclk);
		chk(fault === 1'b1 && busy === 1'b0, "no fault stop");
		chk(drive === '0 && iref === IREF_OFF, "drive not removed");
		abort = 1'b0;
		repeat (3) @(negedge mclk);
		chk(fault === 1'b0, "fault stuck");
	endtask

	// excitation must never drop while a job runs; the first busy cycle is
	// skipped since the windings are powered one edge after the start
	logic busy_q = 1'b0;
	always @(negedge mclk) begin
		if (abort === 1'b0 && busy_q === 1'b1 && busy === 1'b1 &&
			drive.a_en !== 1'b1 && drive.b_en !== 1'b1) begin
			err_count++;
			$display("[FAIL] %0t excitation dropped in job", $time);
		end
		busy_q <= busy;
	end

	// watchdog well beyond the expected run
	initial begin
		#(40 * 20000);
		err_count++;
		stop_test();
	end

	initial begin
		rst_n = 1'b0;
		start = 1'b0;
		lines = 16'h0000;
		reverse = 1'b0;
		abort = 1'b0;
		paper = 1'b1;
		t_feed();
		t_reverse();
		t_no_paper();
		t_abort();
		stop_test();
	end
endmodule
`default_nettype wire
